/* hdl/tec_ctrl_top.sv */
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module tec_ctrl_top (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // Avalon-MM slave
   input  wire logic [tec_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [tec_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [tec_pkg::BE_W-1:0]      avs_byteenable,
   output logic      [tec_pkg::DATA_W-1:0]    avs_readdata,
   output logic                               avs_waitrequest,
   // Timer overflow events
   input  wire logic                          t0_overflow,
   input  wire logic                          t1_overflow,
   // Vectoring acknowledges
   input  wire logic                          t0_vector,
   input  wire logic                          t1_vector,
   input  wire logic                          ext_irq0_vector,
   input  wire logic                          ext_irq1_vector,
   // External interrupt pins and polarity configuration
   input  wire logic                          ext_irq0_input,
   input  wire logic                          ext_irq1_input,
   input  wire logic                          ext_irq0_polarity,
   input  wire logic                          ext_irq1_polarity,
   // Timer controls and flags
   output logic                               t0_run,
   output logic                               t1_run,
   output logic                               t0_overflow_flag,
   output logic                               t1_overflow_flag,
   // External interrupt flags and type selects
   output logic                               ext_irq0_flag,
   output logic                               ext_irq1_flag,
   output logic                               ext_irq0_type_sel,
   output logic                               ext_irq1_type_sel
);

   tec_pkg::tec_bus_state_t                   state_q;
   tec_pkg::tec_bus_state_t                   state_d;
   logic                                      req_c;
   logic                                      ack_c;
   logic                                      ctrl_wr_c;
   logic [tec_pkg::DATA_W-1:0]                rd_mux_c;
   logic [tec_pkg::DATA_W-1:0]                readdata_q;
   logic [tec_pkg::CTRL_W-1:0]                ctrl_c;
   logic [tec_pkg::NUM_TIMERS-1:0]            tmr_ovf_c;
   logic [tec_pkg::NUM_TIMERS-1:0]            tmr_vec_c;
   logic [tec_pkg::NUM_TIMERS-1:0]            run_q;
   logic [tec_pkg::NUM_TIMERS-1:0]            flag_q;
   logic [tec_pkg::NUM_EXT-1:0]               pin_raw_c;
   logic [tec_pkg::NUM_EXT-1:0]               pin_sync;
   logic [tec_pkg::NUM_EXT-1:0]               ext_pol_c;
   logic [tec_pkg::NUM_EXT-1:0]               ext_vec_c;
   logic [tec_pkg::NUM_EXT-1:0]               type_q;
   logic [tec_pkg::NUM_EXT-1:0]               ext_flag;
   logic [tec_pkg::NUM_EXT-1:0]               ext_active;

   // Gather per-channel inputs into vectors
   assign tmr_ovf_c = {t1_overflow, t0_overflow};
   assign tmr_vec_c = {t1_vector, t0_vector};
   assign pin_raw_c = {ext_irq1_input, ext_irq0_input};
   assign ext_pol_c = {ext_irq1_polarity, ext_irq0_polarity};
   assign ext_vec_c = {ext_irq1_vector, ext_irq0_vector};

   // Bus handshake: every access waits exactly one cycle
   assign req_c           = avs_read | avs_write;
   assign avs_waitrequest = req_c & (state_q != tec_pkg::TEC_BUS_ACK);
   assign ack_c           = req_c & ~avs_waitrequest;

   // A control write lands only on the completing edge with lane 0 enabled
   assign ctrl_wr_c = ack_c & avs_write & (avs_address == tec_pkg::ADDR_CTRL)
                      & avs_byteenable[tec_pkg::CTRL_LANE];

   // Bus phase selection
   always_comb begin
      state_d = state_q;
      case (state_q)
         tec_pkg::TEC_BUS_IDLE: begin
            if (req_c) begin
               state_d = tec_pkg::TEC_BUS_ACK;
            end
         end
         tec_pkg::TEC_BUS_ACK: begin
            state_d = tec_pkg::TEC_BUS_IDLE;
         end
         default: begin
            state_d = tec_pkg::TEC_BUS_IDLE;
         end
      endcase
   end

   // Bus phase register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= tec_pkg::TEC_BUS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Assemble the control register image from live state
   always_comb begin
      ctrl_c = tec_pkg::CTRL_RESET;
      for (int i = 0; i < tec_pkg::NUM_TIMERS; i++) begin
         ctrl_c[tec_pkg::TMR_RUN_BIT0 + i * tec_pkg::BIT_STRIDE]  = run_q[i];
         ctrl_c[tec_pkg::TMR_FLAG_BIT0 + i * tec_pkg::BIT_STRIDE] = flag_q[i];
      end
      for (int i = 0; i < tec_pkg::NUM_EXT; i++) begin
         ctrl_c[tec_pkg::EXT_TYPE_BIT0 + i * tec_pkg::BIT_STRIDE] = type_q[i];
         ctrl_c[tec_pkg::EXT_FLAG_BIT0 + i * tec_pkg::BIT_STRIDE] = ext_flag[i];
      end
   end

   // Read decode; unmapped addresses read zero
   always_comb begin
      rd_mux_c = tec_pkg::READ_ZERO;
      case (avs_address)
         tec_pkg::ADDR_CTRL: begin
            rd_mux_c[tec_pkg::CTRL_W-1:0] = ctrl_c;
         end
         tec_pkg::ADDR_STAT: begin
            for (int i = 0; i < tec_pkg::NUM_EXT; i++) begin
               rd_mux_c[tec_pkg::STAT_PIN_BIT0 + i] = pin_sync[i];
               rd_mux_c[tec_pkg::STAT_ACT_BIT0 + i] = ext_active[i];
            end
         end
         default: begin
            rd_mux_c = tec_pkg::READ_ZERO;
         end
      endcase
   end

   // Read data sampled in the waiting cycle and held through the answer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         readdata_q <= tec_pkg::READ_ZERO;
      end else if (avs_read && avs_waitrequest) begin
         readdata_q <= rd_mux_c;
      end
   end

   assign avs_readdata = readdata_q;

   // Timer run controls and overflow flags, one slice per timer
   for (genvar i = 0; i < tec_pkg::NUM_TIMERS; i++) begin : g_tmr
      localparam int RUN_BIT  = tec_pkg::TMR_RUN_BIT0 + i * tec_pkg::BIT_STRIDE;
      localparam int FLAG_BIT = tec_pkg::TMR_FLAG_BIT0 + i * tec_pkg::BIT_STRIDE;

      // Run bit is plain software state
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            run_q[i] <= tec_pkg::CTRL_RESET[RUN_BIT];
         end else if (ctrl_wr_c) begin
            run_q[i] <= avs_writedata[RUN_BIT];
         end
      end

      // Overflow flag: hardware set first, then vectoring clear, then software write
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            flag_q[i] <= tec_pkg::CTRL_RESET[FLAG_BIT];
         end else if (tmr_ovf_c[i]) begin
            flag_q[i] <= 1'b1;
         end else if (tmr_vec_c[i]) begin
            flag_q[i] <= 1'b0;
         end else if (ctrl_wr_c) begin
            flag_q[i] <= avs_writedata[FLAG_BIT];
         end
      end

      tmr_set_a: assert property (@(posedge core_clk) disable iff (rst)
         tmr_ovf_c[i] |=> flag_q[i])
         else $error("overflow did not set the timer flag");

      tmr_vec_clr_a: assert property (@(posedge core_clk) disable iff (rst)
         tmr_vec_c[i] && !tmr_ovf_c[i] |=> !flag_q[i])
         else $error("vectoring did not clear the timer flag");

      tmr_hold_a: assert property (@(posedge core_clk) disable iff (rst)
         !tmr_ovf_c[i] && !tmr_vec_c[i] && !ctrl_wr_c |=> flag_q[i] == $past(flag_q[i]))
         else $error("timer flag changed without cause");

      run_write_a: assert property (@(posedge core_clk) disable iff (rst)
         ctrl_wr_c |=> run_q[i] == $past(avs_writedata[RUN_BIT]))
         else $error("run bit did not take the written value");

      // Software write, hold and readback of the timer bits
      tmr_sw_write_a: assert property (@(posedge core_clk) disable iff (rst)
         ctrl_wr_c && !tmr_ovf_c[i] && !tmr_vec_c[i] |=> flag_q[i] == $past(avs_writedata[FLAG_BIT]))
         else $error("software write did not reach the timer flag");

      run_hold_a: assert property (@(posedge core_clk) disable iff (rst)
         !ctrl_wr_c |=> run_q[i] == $past(run_q[i]))
         else $error("run bit changed without a write");

      read_tmr_a: assert property (@(posedge core_clk) disable iff (rst)
         ack_c && avs_read && avs_address == tec_pkg::ADDR_CTRL
         |-> avs_readdata[FLAG_BIT] == $past(flag_q[i]) && avs_readdata[RUN_BIT] == $past(run_q[i]))
         else $error("timer bits read back wrong");
   end

   // Pin filtering for both external interrupt inputs
   tec_sync #(
      .WIDTH     (tec_pkg::NUM_EXT),
      .RESET_VAL ('0)
   ) u_pin_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (pin_raw_c),
      .sync_out (pin_sync)
   );

   // External interrupt channels: type select here, flag logic in the cell
   for (genvar i = 0; i < tec_pkg::NUM_EXT; i++) begin : g_ext
      localparam int TYPE_BIT = tec_pkg::EXT_TYPE_BIT0 + i * tec_pkg::BIT_STRIDE;
      localparam int FLAG_BIT = tec_pkg::EXT_FLAG_BIT0 + i * tec_pkg::BIT_STRIDE;

      // Type select is plain software state
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            type_q[i] <= tec_pkg::CTRL_RESET[TYPE_BIT];
         end else if (ctrl_wr_c) begin
            type_q[i] <= avs_writedata[TYPE_BIT];
         end
      end

      tec_ext_irq u_ext (
         .core_clk   (core_clk),
         .rst        (rst),
         .pin_level  (pin_sync[i]),
         .polarity   (ext_pol_c[i]),
         .type_sel   (type_q[i]),
         .sw_wr      (ctrl_wr_c),
         .sw_val     (avs_writedata[FLAG_BIT]),
         .vector_ack (ext_vec_c[i]),
         .flag       (ext_flag[i]),
         .active     (ext_active[i])
      );

      type_write_a: assert property (@(posedge core_clk) disable iff (rst)
         ctrl_wr_c |=> type_q[i] == $past(avs_writedata[TYPE_BIT]))
         else $error("type select did not take the written value");

      ext_sw_clr_a: assert property (@(posedge core_clk) disable iff (rst)
         type_q[i] && ctrl_wr_c && !avs_writedata[FLAG_BIT] && !ext_vec_c[i]
         && (ext_pol_c[i] ? pin_sync[i] : !pin_sync[i]) == ext_active[i]
         |=> !ext_flag[i])
         else $error("software clear of edge flag lost");

      // Hold, level tracking, vectoring, software set and readback of each external channel
      type_hold_a: assert property (@(posedge core_clk) disable iff (rst)
         !ctrl_wr_c |=> type_q[i] == $past(type_q[i]))
         else $error("type select changed without a write");

      level_track_a: assert property (@(posedge core_clk) disable iff (rst)
         !type_q[i] |=> ext_flag[i] == ext_active[i])
         else $error("level mode flag differs from the active level");

      ext_vec_clr_a: assert property (@(posedge core_clk) disable iff (rst)
         type_q[i] && ext_vec_c[i] && (ext_pol_c[i] ? pin_sync[i] : !pin_sync[i]) == ext_active[i]
         |=> !ext_flag[i])
         else $error("vectoring did not clear the edge flag");

      ext_sw_set_a: assert property (@(posedge core_clk) disable iff (rst)
         type_q[i] && ctrl_wr_c && avs_writedata[FLAG_BIT] && !ext_vec_c[i] |=> ext_flag[i])
         else $error("software set of edge flag lost");

      read_ext_a: assert property (@(posedge core_clk) disable iff (rst)
         ack_c && avs_read && avs_address == tec_pkg::ADDR_CTRL
         |-> avs_readdata[FLAG_BIT] == $past(ext_flag[i]) && avs_readdata[TYPE_BIT] == $past(type_q[i]))
         else $error("external interrupt bits read back wrong");

      read_stat_a: assert property (@(posedge core_clk) disable iff (rst)
         ack_c && avs_read && avs_address == tec_pkg::ADDR_STAT
         |-> avs_readdata[tec_pkg::STAT_PIN_BIT0 + i] == $past(pin_sync[i])
             && avs_readdata[tec_pkg::STAT_ACT_BIT0 + i] == $past(ext_active[i]))
         else $error("status bits read back wrong");
   end

   // Drive the per-channel outputs
   assign t0_run            = run_q[0];
   assign t1_run            = run_q[1];
   assign t0_overflow_flag  = flag_q[0];
   assign t1_overflow_flag  = flag_q[1];
   assign ext_irq0_flag     = ext_flag[0];
   assign ext_irq1_flag     = ext_flag[1];
   assign ext_irq0_type_sel = type_q[0];
   assign ext_irq1_type_sel = type_q[1];

   wait_one_a: assert property (@(posedge core_clk) disable iff (rst)
      req_c && avs_waitrequest ##1 req_c |-> !avs_waitrequest)
      else $error("bus answer not given after one wait cycle");

   read_t1_a: assert property (@(posedge core_clk) disable iff (rst)
      ack_c && avs_read && avs_address == tec_pkg::ADDR_CTRL
      |-> avs_readdata[tec_pkg::TMR_FLAG_BIT0 + tec_pkg::BIT_STRIDE] == $past(flag_q[1]))
      else $error("timer 1 flag read back wrong");

   read_unmap_a: assert property (@(posedge core_clk) disable iff (rst)
      ack_c && avs_read && avs_address != tec_pkg::ADDR_CTRL && avs_address != tec_pkg::ADDR_STAT
      |-> avs_readdata == tec_pkg::READ_ZERO)
      else $error("unmapped read not zero");

   // Bus phase, read data and refused write checks
   wait_first_a: assert property (@(posedge core_clk) disable iff (rst)
      req_c && state_q == tec_pkg::TEC_BUS_IDLE |-> avs_waitrequest)
      else $error("bus answered without a wait cycle");

   wait_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      !req_c |-> !avs_waitrequest)
      else $error("waitrequest raised with no request");

   ack_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      ack_c |=> state_q == tec_pkg::TEC_BUS_IDLE)
      else $error("bus phase did not return to idle");

   rd_sample_a: assert property (@(posedge core_clk) disable iff (rst)
      avs_read && avs_waitrequest |=> avs_readdata == $past(rd_mux_c))
      else $error("read data not taken in the waiting cycle");

   rdata_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !(avs_read && avs_waitrequest) |=> avs_readdata == $past(avs_readdata))
      else $error("read data changed outside a read");

   read_upper_a: assert property (@(posedge core_clk) disable iff (rst)
      ack_c && avs_read |-> avs_readdata[tec_pkg::DATA_W-1:tec_pkg::CTRL_W] == '0)
      else $error("upper read data bits not zero");

   refuse_wr_a: assert property (@(posedge core_clk) disable iff (rst)
      ack_c && avs_write && (avs_address != tec_pkg::ADDR_CTRL || !avs_byteenable[tec_pkg::CTRL_LANE])
      |=> run_q == $past(run_q) && type_q == $past(type_q))
      else $error("refused write changed the control bits");

endmodule : tec_ctrl_top

/* hdl/tec_ext_irq.sv */
module tec_ext_irq (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Filtered pin level and its configuration
   input  wire logic pin_level,
   input  wire logic polarity,
   input  wire logic type_sel,
   // Software access to the flag
   input  wire logic sw_wr,
   input  wire logic sw_val,
   // Vectoring acknowledge
   input  wire logic vector_ack,
   // Flag and registered active level
   output logic      flag,
   output logic      active
);

   logic active_c;
   logic rise_c;
   logic prev_q;
   logic flag_q;

   // Active level follows the separate polarity bit: one is active high
   assign active_c = polarity ? pin_level : ~pin_level;
   assign rise_c   = active_c & ~prev_q;

   // Previous active level for edge detection
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= active_c;
      end
   end

   // Level mode tracks the pin; edge mode latches, an edge beats any clear, vectoring beats a software set
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (!type_sel) begin
         flag_q <= active_c;
      end else if (rise_c) begin
         flag_q <= 1'b1;
      end else if ((sw_wr && !sw_val) || vector_ack) begin
         flag_q <= 1'b0;
      end else if (sw_wr) begin
         flag_q <= 1'b1;
      end
   end

   assign flag   = flag_q;
   assign active = prev_q;

   level_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      !type_sel |=> flag == $past(active_c))
      else $error("level mode flag does not follow the input");

   edge_set_a: assert property (@(posedge core_clk) disable iff (rst)
      type_sel && rise_c |=> flag)
      else $error("edge not latched into flag");

   edge_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      type_sel && vector_ack && !rise_c |=> !flag)
      else $error("edge flag not cleared by vectoring");

endmodule : tec_ext_irq

/* hdl/tec_sync.sv */
module tec_sync #(
   parameter int               WIDTH     = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Pins from outside the clock domain
   input  wire logic [WIDTH-1:0] async_in,
   // Filtered levels
   output logic      [WIDTH-1:0] sync_out
);

   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;

      // Three stages; the level is taken only when stages two and three agree
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            s1_q  <= RESET_VAL[b];
            s2_q  <= RESET_VAL[b];
            s3_q  <= RESET_VAL[b];
            out_q <= RESET_VAL[b];
         end else begin
            s1_q <= async_in[b];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               out_q <= s3_q;
            end
         end
      end

      assign sync_out[b] = out_q;
   end

endmodule : tec_sync

/* inc/tec_pkg.sv */
package tec_pkg;

   // Register map, byte addresses on the register bus
   localparam int          ADDR_W     = 4;
   localparam logic [3:0]  ADDR_CTRL  = 4'h0;
   localparam logic [3:0]  ADDR_STAT  = 4'h4;

   // Register widths and reset values
   localparam int          DATA_W     = 32;
   localparam int          BE_W       = 4;
   localparam int          CTRL_W     = 8;
   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

   // Byte lane that carries the control register
   localparam int          CTRL_LANE  = 0;

   // Control register field layout: channel i sits at BIT0 + i * BIT_STRIDE
   localparam int          BIT_STRIDE     = 2;
   localparam int          TMR_RUN_BIT0   = 4;
   localparam int          TMR_FLAG_BIT0  = 5;
   localparam int          EXT_TYPE_BIT0  = 0;
   localparam int          EXT_FLAG_BIT0  = 1;

   // Status register field layout: one bit per external channel
   localparam int          STAT_PIN_BIT0  = 0;
   localparam int          STAT_ACT_BIT0  = 2;

   // Channel counts
   localparam int          NUM_TIMERS = 2;
   localparam int          NUM_EXT    = 2;

   // Bus answer phases
   typedef enum logic {
      TEC_BUS_IDLE,
      TEC_BUS_ACK
   } tec_bus_state_t;

endpackage : tec_pkg

/* sim/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int P = 8;
   logic        core_clk, rst, rd_en, wr_en, wait_rq;
   logic [3:0]  adr, be, vec, vec_req;
   logic [31:0] wdat, rdat, got, v;
   logic [1:0]  ovf, ovf_req, pin, pol;
   logic        t0r, t1r, t0f, t1f, e0f, e1f, e0t, e1t;
   logic [7:0]  ctl, w, pw;
   int          miscompares, comparisons;

   assign ctl = {t1f, t1r, t0f, t0r, e1f, e1t, e0f, e0t};

   tec_ctrl_top uut (
      .core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
      .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_rq),
      .t0_overflow(ovf[0]), .t1_overflow(ovf[1]), .t0_vector(vec[0]), .t1_vector(vec[1]),
      .ext_irq0_vector(vec[2]), .ext_irq1_vector(vec[3]), .ext_irq0_input(pin[0]),
      .ext_irq1_input(pin[1]), .ext_irq0_polarity(pol[0]), .ext_irq1_polarity(pol[1]),
      .t0_run(t0r), .t1_run(t1r), .t0_overflow_flag(t0f), .t1_overflow_flag(t1f),
      .ext_irq0_flag(e0f), .ext_irq1_flag(e1f), .ext_irq0_type_sel(e0t), .ext_irq1_type_sel(e1t)
   );

   tec_cpu_model #(.TMR_PERIOD(P)) partner (
      .core_clk(core_clk), .rst(rst), .t0_run(t0r), .t1_run(t1r), .ovf_req(ovf_req),
      .vec_req(vec_req), .t0_overflow(ovf[0]), .t1_overflow(ovf[1]), .t0_vector(vec[0]),
      .t1_vector(vec[1]), .ext_irq0_vector(vec[2]), .ext_irq1_vector(vec[3])
   );

   // Free-running clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, seen, exp);
      end
   endtask : check

   // One bus transfer, held until waitrequest is sampled low
   task automatic xfer(input logic [3:0] a, input logic wr, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      adr   <= a;
      wr_en <= wr;
      rd_en <= !wr;
      wdat  <= d;
      be    <= b;
      do begin
         @(posedge core_clk);
         n++;
      end while (wait_rq !== 1'b0 && n < 20);
      got = rdat;
      if (wait_rq !== 1'b0) begin
         miscompares++;
         wrap_up();
      end
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge core_clk);
   endtask : xfer

   task automatic wr(input logic [7:0] d);
      xfer(tec_pkg::ADDR_CTRL, 1'b1, {24'h00_0000, d}, 4'hf);
   endtask : wr

   // Read control, compare bus value and port outputs
   task automatic rc(input logic [7:0] e, input string m);
      xfer(tec_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000, 4'hf);
      check(got, 32'(e), m);
      check(32'(ctl), 32'(e), m);
   endtask : rc

   // Command pulses to the partner
   task automatic pulse(input logic [1:0] o, input logic [3:0] q);
      ovf_req <= o;
      vec_req <= q;
      @(posedge core_clk);
      ovf_req <= 2'h0;
      vec_req <= 4'h0;
      repeat (3) @(posedge core_clk);
   endtask : pulse

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle

   // Level-mode flags read back as zero with the pins held inactive; a flag write lands only where edge mode was already set
   function automatic logic [7:0] exp_ctrl(input logic [7:0] d, input logic [7:0] p);
      exp_ctrl = d;
      for (int i = 0; i < 2; i++) begin
         if (!d[2*i] || !p[2*i]) exp_ctrl[1+2*i] = 1'b0;
      end
   endfunction : exp_ctrl

   // Main sequence
   initial begin
      rst = 1'b1;
      {adr, be, rd_en, wr_en, wdat, ovf_req, vec_req} = '0;
      pol = 2'h3;
      pin = 2'h0;
      miscompares = 0;
      comparisons = 0;
      v = $urandom(32'h1f2d_289a);
      idle(2);
      rst <= 1'b0;
      @(posedge core_clk);
      rc(tec_pkg::CTRL_RESET, "reset value");
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         wr(8'h00);
         idle(2 * P);
         rc(8'h00, "timer stopped");
         wr(8'h10 << (2 * i));
         idle(P + 2);
         rc(8'h30 << (2 * i), "timer overflow");
         wr(8'h20 << (2 * i));
         pulse(2'h0, 4'h1 << i);
         idle(2 * P);
         rc(8'h00, "vector clear");
         wr(8'h20 << (2 * i));
         wr(8'h00);
         rc(8'h00, "software clear");
         pulse(2'h1 << i, 4'h1 << i);
         rc(8'h20 << (2 * i), "set wins");
      end
      $display("test timers done");
      for (int k = 0; k < 4; k++) begin
         wr(8'h00);
         pol[k%2] <= k[1];
         pin[k%2] <= k[1];
         idle(8);
         xfer(tec_pkg::ADDR_STAT, 1'b0, 32'h0000_0000, 4'hf);
         check(32'(got[k%2]), 32'(k[1]), "pin level");
         check(32'(got[2+k%2]), 32'h0000_0001, "active level");
         wr(8'h00);
         pulse(2'h0, 4'h4 << (k % 2));
         rc(8'h02 << (2 * (k % 2)), "level active");
         pin[k%2] <= !k[1];
         idle(8);
         rc(8'h00, "level idle");
      end
      $display("test level done");
      for (int k = 0; k < 4; k++) begin
         pol[k%2] <= k[1];
         pin[k%2] <= !k[1];
         idle(8);
         w = 8'h01 << (2 * (k % 2));
         wr(w);
         pin[k%2] <= k[1];
         idle(8);
         rc(w | (w << 1), "edge set");
         pin[k%2] <= !k[1];
         idle(8);
         rc(w | (w << 1), "edge held");
         pulse(2'h0, 4'h4 << (k % 2));
         rc(w, "edge vector");
         pin[k%2] <= k[1];
         idle(8);
         wr(w);
         rc(w, "edge software clear");
         pin[k%2] <= !k[1];
         idle(8);
         wr(8'h00);
      end
      $display("test edge done");
      pw = 8'h00;
      for (int n = 0; n < 24; n++) begin
         v = $urandom;
         pol <= v[9:8];
         pin <= ~v[9:8];
         idle(8);
         w = v[7:0] & 8'haf;
         xfer(tec_pkg::ADDR_CTRL, 1'b1, {v[31:24], v[23:8], w}, v[15:12] | 4'h1);
         rc(exp_ctrl(w, pw), "random");
         pw = w;
      end
      $display("test random done");
      wr(8'h00);
      xfer(tec_pkg::ADDR_STAT, 1'b1, 32'h0000_00ff, 4'hf);
      xfer(tec_pkg::ADDR_CTRL, 1'b1, 32'h0000_00ff, 4'he);
      rc(8'h00, "refused write");
      xfer(4'h8, 1'b0, 32'h0000_0000, 4'hf);
      check(got, tec_pkg::READ_ZERO, "unmapped read");
      $display("test refused done");
      wrap_up();
   end
endmodule : tb

/* sim/tec_cpu_model.sv */
module tec_cpu_model #(
   parameter int TMR_PERIOD = 8
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Timer run controls
   input  wire logic       t0_run,
   input  wire logic       t1_run,
   // Bench commands, one-cycle pulses
   input  wire logic [1:0] ovf_req,
   input  wire logic [3:0] vec_req,
   // Events toward the block
   output logic            t0_overflow,
   output logic            t1_overflow,
   output logic            t0_vector,
   output logic            t1_vector,
   output logic            ext_irq0_vector,
   output logic            ext_irq1_vector
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] cnt_q [0:1];
   logic [1:0] ovf_q;
   logic [3:0] vec_q;
   logic [1:0] run;

   assign run = {t1_run, t0_run};

   // Timers advance only while run is set and pulse at wrap
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q[0] <= 8'h00;
         cnt_q[1] <= 8'h00;
         ovf_q    <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ovf_q[i] <= ovf_req[i] | (run[i] && cnt_q[i] == 8'(TMR_PERIOD - 1));
            if (run[i]) begin
               cnt_q[i] <= (cnt_q[i] == 8'(TMR_PERIOD - 1)) ? 8'h00 : cnt_q[i] + 8'h01;
            end
         end
      end
   end

   // Vectoring acknowledges, one cycle after the command
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         vec_q <= 4'h0;
      end else begin
         vec_q <= vec_req;
      end
   end

   assign {t1_overflow, t0_overflow} = ovf_q;
   assign {ext_irq1_vector, ext_irq0_vector, t1_vector, t0_vector} = vec_q;
endmodule : tec_cpu_model
